/* rtl/ppc_pkg.sv */
// constants for the port pin control block
package ppc_pkg;
    // port widths
    localparam int SP_W  = 8;             // serial-function port
    localparam int RX_W  = 8;             // mii receive port
    localparam int TX_W  = 7;             // mii transmit port
    localparam int MII_W = 7;             // pins taken by the mac
    localparam int IDX_W = 6;             // register index width
    // register indices, byte address is four times the index
    localparam logic [5:0] IDX_SP_PULL_EN  = 6'h0c;
    localparam logic [5:0] IDX_SP_PULL_SEL = 6'h0d;
    localparam logic [5:0] IDX_SP_OPEN_DR  = 6'h0e;
    localparam logic [5:0] IDX_RX_DATA     = 6'h10;
    localparam logic [5:0] IDX_RX_PIN_IN   = 6'h11;
    localparam logic [5:0] IDX_RX_DIR      = 6'h12;
    localparam logic [5:0] IDX_RX_RDRV     = 6'h13;
    localparam logic [5:0] IDX_RX_PULL_EN  = 6'h14;
    localparam logic [5:0] IDX_RX_POL_SEL  = 6'h15;
    localparam logic [5:0] IDX_RX_IRQ_EN   = 6'h16;
    localparam logic [5:0] IDX_RX_IRQ_FLG  = 6'h17;
    localparam logic [5:0] IDX_TX_DATA     = 6'h18;
    localparam logic [5:0] IDX_TX_PIN_IN   = 6'h19;
    localparam logic [5:0] IDX_TX_DIR      = 6'h1a;
    // address field positions
    localparam int ADDR_IDX_LSB = 2;
    localparam int ADDR_IDX_MSB = 7;
    // reset values
    localparam logic [7:0] RST_SP_PULL_EN  = 8'hff;
    localparam logic [7:0] RST_SP_PULL_SEL = 8'h00;
    localparam logic [7:0] RST_SP_OPEN_DR  = 8'h00;
    localparam logic [7:0] RST_RX_PULL_EN  = 8'h00;
    localparam logic [7:0] RST_ZERO8       = 8'h00;
    localparam logic [6:0] RST_ZERO7       = 7'h00;
    localparam logic [31:0] RST_ZERO32     = 32'h0000_0000;
    // bus encodings
    localparam logic [1:0] HTRANS_IDLE   = 2'b00;
    localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
    localparam logic       HRESP_OKAY    = 1'b0;
endpackage : ppc_pkg

/* rtl/ppc_top.sv */
// port pin control: serial port pulls, mii receive and transmit ports
//
// Notes on behaviour
// - serial pull acts on input or wired-or pins, never push-pull outputs
// - serial port pulls enabled, pull-up selected, out of reset
// - serial pull select 1 gives pull-down, 0 gives pull-up
// - serial open-drain drives low only, also for peripheral outputs
// - open-drain setting leaves input pins untouched
// - data read gives latch where the direction bit is 1, pin level where it is 0, also in mac external mode
// - pin input registers read pin levels always, writes ignored
// - direction bit 1 makes output, 0 makes input
// - reads settle within three cycles after a direction change
// - mac external mode: low seven receive pins carry mii receive inputs
// - mac external mode forces those receive pins to inputs
// - mac disabled: receive direction bits control pins again
// - reduced drive bit 1 gives weak drive, ignored on inputs
// - receive port pulls off at reset, act only on inputs
// - polarity 1: rising edge and pull-down; 0: falling edge and pull-up
// - per-pin interrupt enable, 0 masks the flag
// - active edge sets flag; write 1 clears, write 0 keeps
// - interrupt request while any enabled flag is set
// - mac external mode: transmit port carries mii transmit signals
// - transmit direction bits ignored while mac owns the port
//
// The AHB-Lite register port was chosen for this implementation.
`timescale 1ns/1ps
module ppc_top #(
    parameter int ADDR_W = 8                          // bus address width
) (
    input  wire logic                      clock,         // bus clock
    input  wire logic                      rst_b,         // async reset, low
    input  wire logic                      hsel,          // slave select
    input  wire logic [ADDR_W-1:0]         haddr,         // byte address
    input  wire logic [1:0]                htrans,        // transfer type
    input  wire logic                      hwrite,        // write transfer
    input  wire logic [2:0]                hsize,         // transfer size
    input  wire logic [31:0]               hwdata,        // write data
    input  wire logic                      hready,        // bus ready
    output logic                           hreadyout,     // slave ready
    output logic                           hresp,         // response
    output logic [31:0]                    hrdata,        // read data
    input  wire logic [ppc_pkg::SP_W-1:0]  sp_dir,        // serial pin dir
    input  wire logic [ppc_pkg::SP_W-1:0]  sp_dout,       // serial pin data
    output logic [ppc_pkg::SP_W-1:0]       sp_out,        // serial pad out
    output logic [ppc_pkg::SP_W-1:0]       sp_oe,         // serial pad enable
    output logic [ppc_pkg::SP_W-1:0]       sp_pull_en,    // serial pull on
    output logic [ppc_pkg::SP_W-1:0]       sp_pull_dn,    // serial pull down
    input  wire logic                      mii_ext_en,    // mac external phy
    input  wire logic [ppc_pkg::RX_W-1:0]  rxp_in,        // receive pad in
    output logic [ppc_pkg::RX_W-1:0]       rxp_out,       // receive pad out
    output logic [ppc_pkg::RX_W-1:0]       rxp_oe,        // receive pad enable
    output logic [ppc_pkg::RX_W-1:0]       rxp_rdrv,      // reduced drive
    output logic [ppc_pkg::RX_W-1:0]       rxp_pull_en,   // receive pull on
    output logic [ppc_pkg::RX_W-1:0]       rxp_pull_dn,   // receive pull down
    output logic [ppc_pkg::MII_W-1:0]      mii_rx,        // to mac receive
    output logic                           port_irq,      // interrupt request
    input  wire logic [ppc_pkg::TX_W-1:0]  txp_in,        // transmit pad in
    output logic [ppc_pkg::TX_W-1:0]       txp_out,       // transmit pad out
    output logic [ppc_pkg::TX_W-1:0]       txp_oe,        // transmit pad enable
    input  wire logic [ppc_pkg::MII_W-1:0] mii_tx_out,    // from mac
    input  wire logic [ppc_pkg::MII_W-1:0] mii_tx_oe,     // from mac
    output logic [ppc_pkg::MII_W-1:0]      mii_tx_in      // to mac
);
    import ppc_pkg::*;

    // software registers
    logic [SP_W-1:0]  sp_pe_q;
    logic [SP_W-1:0]  sp_ps_q;
    logic [SP_W-1:0]  sp_od_q;
    logic [RX_W-1:0]  rx_dat_q;
    logic [RX_W-1:0]  rx_dir_q;
    logic [RX_W-1:0]  rx_rdr_q;
    logic [RX_W-1:0]  rx_pe_q;
    logic [RX_W-1:0]  rx_ps_q;
    logic [RX_W-1:0]  rx_ie_q;
    logic [RX_W-1:0]  rx_fl_q;
    logic [TX_W-1:0]  tx_dat_q;
    logic [TX_W-1:0]  tx_dir_q;
    // pin synchronisers
    logic [RX_W-1:0]  rx_s1_q;
    logic [RX_W-1:0]  rx_s2_q;
    logic [RX_W-1:0]  rx_s3_q;
    logic [TX_W-1:0]  tx_s1_q;
    logic [TX_W-1:0]  tx_s2_q;
    // bus data phase state
    logic             acc;
    logic             wr_q;
    logic             rd_q;
    logic [IDX_W-1:0] idx_q;
    logic [7:0]       wb;
    logic             hreadyout_q;
    logic [31:0]      hrdata_q;
    // derived pin state
    logic [RX_W-1:0]  rx_edir;
    logic [RX_W-1:0]  rx_set;
    logic [RX_W-1:0]  rx_clr;
    logic [SP_W-1:0]  sp_act;

    assign hreadyout = hreadyout_q;
    assign hrdata    = hrdata_q;
    assign wb        = hwdata[7:0];

    // write strobe for one register in the data phase
    function automatic logic wr_hit(input logic [IDX_W-1:0] idx);
        wr_hit = wr_q && (idx_q == idx);
    endfunction : wr_hit

    // register read mux
    function automatic logic [7:0] rd_val(input logic [IDX_W-1:0] idx);
        rd_val = RST_ZERO8;
        unique case (idx)
            IDX_SP_PULL_EN:  rd_val = sp_pe_q;
            IDX_SP_PULL_SEL: rd_val = sp_ps_q;
            IDX_SP_OPEN_DR:  rd_val = sp_od_q;
            IDX_RX_DATA:     rd_val = (rx_dir_q & rx_dat_q) | (~rx_dir_q & rx_s2_q);
            IDX_RX_PIN_IN:   rd_val = rx_s2_q;
            IDX_RX_DIR:      rd_val = rx_dir_q;
            IDX_RX_RDRV:     rd_val = rx_rdr_q;
            IDX_RX_PULL_EN:  rd_val = rx_pe_q;
            IDX_RX_POL_SEL:  rd_val = rx_ps_q;
            IDX_RX_IRQ_EN:   rd_val = rx_ie_q;
            IDX_RX_IRQ_FLG:  rd_val = rx_fl_q;
            IDX_TX_DATA:     rd_val = {1'b0, (tx_dir_q & tx_dat_q) | (~tx_dir_q & tx_s2_q)};
            IDX_TX_PIN_IN:   rd_val = {1'b0, tx_s2_q};
            IDX_TX_DIR:      rd_val = {1'b0, tx_dir_q};
            default:         rd_val = RST_ZERO8;
        endcase
    endfunction : rd_val

    // address phase taken only for a selected, ready, non-idle transfer
    assign acc = hsel && htrans[1] && hready;

    // data phase tracking; reads take one wait state
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            wr_q        <= 1'b0;
            rd_q        <= 1'b0;
            idx_q       <= '0;
            hreadyout_q <= 1'b1;
        end else begin
            wr_q        <= acc && hwrite;
            rd_q        <= acc && !hwrite;
            hreadyout_q <= !(acc && !hwrite);
            if (acc) begin
                idx_q <= haddr[ADDR_IDX_MSB:ADDR_IDX_LSB];
            end
        end
    end

    // read data captured in the wait state, after any earlier write landed
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            hrdata_q <= RST_ZERO32;
            hresp    <= HRESP_OKAY;
        end else begin
            hresp <= HRESP_OKAY;
            if (rd_q) begin
                hrdata_q <= {24'h00_0000, rd_val(idx_q)};
            end
        end
    end

    // serial port configuration registers
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            sp_pe_q <= RST_SP_PULL_EN;
            sp_ps_q <= RST_SP_PULL_SEL;
            sp_od_q <= RST_SP_OPEN_DR;
        end else begin
            if (wr_hit(IDX_SP_PULL_EN))  sp_pe_q <= wb;
            if (wr_hit(IDX_SP_PULL_SEL)) sp_ps_q <= wb;
            if (wr_hit(IDX_SP_OPEN_DR))  sp_od_q <= wb;
        end
    end

    // receive and transmit port registers; input registers take no write
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            rx_dat_q <= RST_ZERO8;
            rx_dir_q <= RST_ZERO8;
            rx_rdr_q <= RST_ZERO8;
            rx_pe_q  <= RST_RX_PULL_EN;
            rx_ps_q  <= RST_ZERO8;
            rx_ie_q  <= RST_ZERO8;
            tx_dat_q <= RST_ZERO7;
            tx_dir_q <= RST_ZERO7;
        end else begin
            if (wr_hit(IDX_RX_DATA))    rx_dat_q <= wb;
            if (wr_hit(IDX_RX_DIR))     rx_dir_q <= wb;
            if (wr_hit(IDX_RX_RDRV))    rx_rdr_q <= wb;
            if (wr_hit(IDX_RX_PULL_EN)) rx_pe_q  <= wb;
            if (wr_hit(IDX_RX_POL_SEL)) rx_ps_q  <= wb;
            if (wr_hit(IDX_RX_IRQ_EN))  rx_ie_q  <= wb;
            if (wr_hit(IDX_TX_DATA))    tx_dat_q <= wb[TX_W-1:0];
            if (wr_hit(IDX_TX_DIR))     tx_dir_q <= wb[TX_W-1:0];
        end
    end

    // two-stage pin synchronisers plus one history stage for edges
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            rx_s1_q <= RST_ZERO8;
            rx_s2_q <= RST_ZERO8;
            rx_s3_q <= RST_ZERO8;
            tx_s1_q <= RST_ZERO7;
            tx_s2_q <= RST_ZERO7;
        end else begin
            rx_s1_q <= rxp_in;
            rx_s2_q <= rx_s1_q;
            rx_s3_q <= rx_s2_q;
            tx_s1_q <= txp_in;
            tx_s2_q <= tx_s1_q;
        end
    end

    // mac mode forces the low receive pins to input
    assign rx_edir = rx_dir_q & ~{1'b0, {MII_W{mii_ext_en}}};

    // active edge per pin from successive samples, selected by polarity
    assign rx_set = ~rx_edir & ((rx_ps_q & rx_s2_q & ~rx_s3_q)
                              | (~rx_ps_q & ~rx_s2_q & rx_s3_q));
    assign rx_clr = wr_hit(IDX_RX_IRQ_FLG) ? wb : RST_ZERO8;

    // sticky flags, a new edge wins over a clear
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            rx_fl_q  <= RST_ZERO8;
            port_irq <= 1'b0;
        end else begin
            rx_fl_q  <= (rx_fl_q & ~rx_clr) | rx_set;
            port_irq <= |(rx_fl_q & rx_ie_q);
        end
    end

    // serial pull acts on inputs and wired-or outputs
    assign sp_act = sp_pe_q & (~sp_dir | sp_od_q);

    // serial pads, open-drain only releases a high level
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            sp_out     <= RST_ZERO8;
            sp_oe      <= RST_ZERO8;
            sp_pull_en <= RST_ZERO8;
            sp_pull_dn <= RST_ZERO8;
        end else begin
            sp_out     <= sp_dout & ~sp_od_q;
            sp_oe      <= sp_dir & ~(sp_od_q & sp_dout);
            sp_pull_en <= sp_act;
            sp_pull_dn <= sp_ps_q;
        end
    end

    // receive pads and the mac receive inputs
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            rxp_out     <= RST_ZERO8;
            rxp_oe      <= RST_ZERO8;
            rxp_rdrv    <= RST_ZERO8;
            rxp_pull_en <= RST_ZERO8;
            rxp_pull_dn <= RST_ZERO8;
            mii_rx      <= RST_ZERO7;
        end else begin
            rxp_out     <= rx_dat_q;
            rxp_oe      <= rx_edir;
            rxp_rdrv    <= rx_rdr_q & rx_edir;
            rxp_pull_en <= rx_pe_q & ~rx_edir;
            rxp_pull_dn <= rx_ps_q;
            mii_rx      <= rx_s2_q[MII_W-1:0];
        end
    end

    // transmit pads, taken over by the mac in external mode
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            txp_out   <= RST_ZERO7;
            txp_oe    <= RST_ZERO7;
            mii_tx_in <= RST_ZERO7;
        end else begin
            txp_out   <= mii_ext_en ? mii_tx_out : tx_dat_q;
            txp_oe    <= mii_ext_en ? mii_tx_oe : tx_dir_q;
            mii_tx_in <= tx_s2_q;
        end
    end

    // checks on the pin, flag and bus read wait behaviour
    property p_sp_od_low;
        @(posedge clock) disable iff (!rst_b)
        ##1 ((sp_oe & sp_out & $past(sp_od_q)) == RST_ZERO8);
    endproperty
    a_sp_od_low: assert property (p_sp_od_low) else $error("open-drain drove high");

    property p_sp_pull_pp;
        @(posedge clock) disable iff (!rst_b)
        ##1 ((sp_pull_en & $past(sp_dir & ~sp_od_q)) == RST_ZERO8);
    endproperty
    a_sp_pull_pp: assert property (p_sp_pull_pp) else $error("pull on push-pull pin");

    property p_sp_in_od;
        @(posedge clock) disable iff (!rst_b)
        ##1 ((sp_oe & ~$past(sp_dir)) == RST_ZERO8);
    endproperty
    a_sp_in_od: assert property (p_sp_in_od) else $error("input pin driven");

    property p_rx_force;
        @(posedge clock) disable iff (!rst_b)
        mii_ext_en |=> (rxp_oe[MII_W-1:0] == RST_ZERO7);
    endproperty
    a_rx_force: assert property (p_rx_force) else $error("mii receive pin driven");

    property p_rx_back;
        @(posedge clock) disable iff (!rst_b)
        !mii_ext_en |=> (rxp_oe == $past(rx_dir_q));
    endproperty
    a_rx_back: assert property (p_rx_back) else $error("direction not restored");

    property p_tx_mii;
        @(posedge clock) disable iff (!rst_b)
        mii_ext_en |=> (txp_oe == $past(mii_tx_oe)) && (txp_out == $past(mii_tx_out));
    endproperty
    a_tx_mii: assert property (p_tx_mii) else $error("mac lost transmit port");

    property p_rdrv_in;
        @(posedge clock) disable iff (!rst_b)
        ##1 ((rxp_rdrv & ~rxp_oe) == RST_ZERO8);
    endproperty
    a_rdrv_in: assert property (p_rdrv_in) else $error("reduced drive on input");

    property p_edge_once;
        @(posedge clock) disable iff (!rst_b)
        ##1 ((rx_set & $past(rx_set)) == RST_ZERO8);
    endproperty
    a_edge_once: assert property (p_edge_once) else $error("edge seen twice");

    property p_flag_set;
        @(posedge clock) disable iff (!rst_b)
        |rx_set |=> ((rx_fl_q & $past(rx_set)) == $past(rx_set));
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("edge lost");

    property p_irq;
        @(posedge clock) disable iff (!rst_b)
        |(rx_fl_q & rx_ie_q) |=> port_irq;
    endproperty
    a_irq: assert property (p_irq) else $error("irq not raised");

    property p_rd_wait;
        @(posedge clock) disable iff (!rst_b)
        (acc && !hwrite) |=> !hreadyout ##1 hreadyout;
    endproperty
    a_rd_wait: assert property (p_rd_wait) else $error("read wait state wrong");

    c_flag_clear: cover property (@(posedge clock) disable iff (!rst_b)
        |rx_fl_q ##1 wr_hit(IDX_RX_IRQ_FLG) ##1 (rx_fl_q == RST_ZERO8));
    c_mii_on: cover property (@(posedge clock) disable iff (!rst_b)
        $rose(mii_ext_en) ##2 |rx_dir_q);
    c_irq_up: cover property (@(posedge clock) disable iff (!rst_b) $rose(port_irq));
endmodule : ppc_top

/* test/ppc_board_model.sv */
// board pads and external phy levels on the receive and transmit ports
`timescale 1ns/1ps
module ppc_board_model (
    input  wire logic       clock,        // bus clock
    input  wire logic [7:0] rxp_out,      // receive pad data
    input  wire logic [7:0] rxp_oe,       // receive pad enable
    input  wire logic [7:0] rxp_pull_en,  // receive pull on
    input  wire logic [7:0] rxp_pull_dn,  // receive pull down
    input  wire logic [6:0] txp_out,      // transmit pad data
    input  wire logic [6:0] txp_oe,       // transmit pad enable
    input  wire logic [7:0] ext_rx,       // level the board puts on rx pins
    input  wire logic [7:0] ext_on,       // board drives rx pins
    input  wire logic [6:0] ext_tx,       // board or phy level on tx pins
    output logic      [7:0] rxp_in,       // resolved rx pads
    output logic      [6:0] txp_in        // resolved tx pads
);
    logic [7:0] float_q = 8'h5a;          // undriven pad wanders every cycle

    // pattern for pads nobody drives, so no stale level is seen
    always_ff @(posedge clock) begin
        float_q <= {float_q[6:0], ~float_q[7]};
    end

    // the block's driver wins, then the board, then a pull, else floating
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (rxp_oe[i]) rxp_in[i] = rxp_out[i];
            else if (ext_on[i]) rxp_in[i] = ext_rx[i];
            else if (rxp_pull_en[i]) rxp_in[i] = ~rxp_pull_dn[i];
            else rxp_in[i] = float_q[i];
        end
        txp_in = (txp_out & txp_oe) | (ext_tx & ~txp_oe);
    end
endmodule : ppc_board_model

/* test/port_pin_control_s_g_h_test.sv */
// self-checking bench for the port pin control block
`timescale 1ns/1ps
module port_pin_control_s_g_h_test;
    import ppc_pkg::*;
    logic        clock = 1'b0, rst_b = 1'b0, hsel = 1'b0, hwrite = 1'b0, mii_ext_en = 1'b0;
    logic [7:0]  haddr = 8'h00, sp_dir = 8'h00, sp_dout = 8'h00, ext_rx = 8'h00;
    logic [7:0]  ext_on = 8'hff;
    logic [1:0]  htrans = HTRANS_IDLE;
    logic [2:0]  hsize = 3'b010;
    logic [31:0] hwdata = RST_ZERO32, hrdata, rnd = 32'ha4f7_48aa;
    logic        hready, hreadyout, hresp, port_irq, rd_dphase = 1'b0;
    logic [7:0]  sp_out, sp_oe, sp_pull_en, sp_pull_dn;
    logic [7:0]  rxp_in, rxp_out, rxp_oe, rxp_rdrv, rxp_pull_en, rxp_pull_dn;
    logic [6:0]  txp_in, txp_out, txp_oe, mii_rx, mii_tx_in, ext_tx = 7'h00;
    logic [6:0]  mii_tx_out = 7'h00, mii_tx_oe = 7'h00;
    logic [31:0] exp_q[$];
    int          miscompares = 0, total_checks = 0, cycles = 0;
    localparam logic [5:0] ZIDX [10] = '{IDX_SP_PULL_SEL, IDX_SP_OPEN_DR, IDX_RX_DIR,
        IDX_RX_RDRV, IDX_RX_PULL_EN, IDX_RX_POL_SEL, IDX_RX_IRQ_EN, IDX_RX_IRQ_FLG,
        IDX_TX_DIR, 6'h3f};
    localparam logic [5:0] RWIDX [9] = '{IDX_SP_PULL_EN, IDX_SP_PULL_SEL, IDX_SP_OPEN_DR,
        IDX_RX_DIR, IDX_RX_RDRV, IDX_RX_PULL_EN, IDX_RX_POL_SEL, IDX_RX_IRQ_EN, IDX_TX_DIR};

    assign hready = hreadyout;            // single slave drives bus ready

    ppc_top dut_u (.clock(clock), .rst_b(rst_b), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .sp_dir(sp_dir),
        .sp_dout(sp_dout), .sp_out(sp_out), .sp_oe(sp_oe), .sp_pull_en(sp_pull_en),
        .sp_pull_dn(sp_pull_dn), .mii_ext_en(mii_ext_en), .rxp_in(rxp_in),
        .rxp_out(rxp_out), .rxp_oe(rxp_oe), .rxp_rdrv(rxp_rdrv), .rxp_pull_en(rxp_pull_en),
        .rxp_pull_dn(rxp_pull_dn), .mii_rx(mii_rx), .port_irq(port_irq), .txp_in(txp_in),
        .txp_out(txp_out), .txp_oe(txp_oe), .mii_tx_out(mii_tx_out),
        .mii_tx_oe(mii_tx_oe), .mii_tx_in(mii_tx_in));

    ppc_board_model board_u (.clock(clock), .rxp_out(rxp_out), .rxp_oe(rxp_oe),
        .rxp_pull_en(rxp_pull_en), .rxp_pull_dn(rxp_pull_dn), .txp_out(txp_out),
        .txp_oe(txp_oe), .ext_rx(ext_rx), .ext_on(ext_on), .ext_tx(ext_tx),
        .rxp_in(rxp_in), .txp_in(txp_in));

    // free-running bus clock, 8 ns period
    initial forever #4 clock = ~clock;

    function automatic logic [31:0] lfsr(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction : lfsr

    task automatic tally_and_finish;
        if (miscompares == 0 && total_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : tally_and_finish

    task automatic check(input logic [31:0] got, input logic [31:0] want);
        total_checks++;
        if (got !== want) begin
            miscompares++;
            $display("unexpected at %0t: got %h want %h", $time, got, want);
        end
    endtask : check

    // one single transfer; for a read d is the value the monitor expects
    task automatic bus(input logic wr, input logic [5:0] idx, input logic [7:0] d);
        if (!wr) exp_q.push_back({24'h00_0000, d});
        @(posedge clock);
        hsel <= 1'b1;
        htrans <= HTRANS_NONSEQ;
        hwrite <= wr;
        haddr <= {idx, 2'b00};
        @(posedge clock);
        while (hready !== 1'b1) @(posedge clock);
        hsel <= 1'b0;
        htrans <= HTRANS_IDLE;
        hwdata <= {24'h00_0000, d};
        @(posedge clock);
        while (hready !== 1'b1) @(posedge clock);
    endtask : bus

    task automatic settle(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : settle

    // read data monitor: takes the oldest note when a read data phase ends
    always @(posedge clock) begin
        if (rd_dphase && hready === 1'b1) check(hrdata, exp_q.pop_front());
        if (rd_dphase && hready === 1'b1) check(hresp, RST_ZERO32);
        if (hready === 1'b1) rd_dphase <= hsel && htrans[1] && !hwrite;
    end

    // hang guard
    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            tally_and_finish();
        end
    end

    initial begin
        logic [7:0] a, b, c, d, e, f, pad;
        logic [6:0] pt;
        repeat (8) @(posedge clock);
        rst_b <= 1'b1;
        settle(2);
        check(sp_pull_en, 8'hff);
        check(sp_pull_dn, 8'h00);
        bus(1'b0, IDX_SP_PULL_EN, RST_SP_PULL_EN);
        foreach (ZIDX[i]) bus(1'b0, ZIDX[i], 8'h00);
        // every read-write register except the two data registers keeps what was written
        foreach (RWIDX[i]) begin
            rnd = lfsr(rnd);
            bus(1'b1, RWIDX[i], rnd[7:0]);
            bus(1'b0, RWIDX[i], (RWIDX[i] == IDX_TX_DIR) ? rnd[7:0] & 8'h7f : rnd[7:0]);
        end
        // serial port pad and pull control
        repeat (16) begin
            rnd = lfsr(rnd);
            {a, b, c, d} = rnd;
            bus(1'b1, IDX_SP_OPEN_DR, a);
            bus(1'b1, IDX_SP_PULL_EN, b);
            bus(1'b1, IDX_SP_PULL_SEL, c);
            rnd = lfsr(rnd);
            @(posedge clock);
            sp_dir <= d;
            sp_dout <= rnd[7:0];
            settle(2);
            check(sp_out, rnd[7:0] & ~a);
            check(sp_oe, d & ~(a & rnd[7:0]));
            check(sp_pull_en, b & (~d | a));
            check(sp_pull_dn, c);
        end
        // reset again in mid-run: pull defaults come back
        @(posedge clock);
        rst_b <= 1'b0;
        repeat (2) @(posedge clock);
        rst_b <= 1'b1;
        settle(2);
        check(sp_pull_en, {24'h00_0000, ~sp_dir});
        check(sp_pull_dn, 8'h00);
        check(rxp_pull_en, 8'h00);
        // receive and transmit ports as general pins
        repeat (16) begin
            rnd = lfsr(rnd);
            {a, b, c, d} = rnd;
            {e, f} = rnd[15:0] ^ rnd[31:16];
            @(posedge clock);
            ext_rx <= c;
            ext_tx <= d[6:0];
            bus(1'b1, IDX_RX_DATA, a);
            bus(1'b1, IDX_RX_DIR, b);
            bus(1'b1, IDX_RX_RDRV, e);
            bus(1'b1, IDX_RX_PULL_EN, f);
            bus(1'b1, IDX_RX_POL_SEL, d);
            bus(1'b1, IDX_TX_DATA, a);
            bus(1'b1, IDX_TX_DIR, b);
            bus(1'b1, IDX_RX_PIN_IN, ~a);
            pad = (a & b) | (c & ~b);
            pt = (a[6:0] & b[6:0]) | (d[6:0] & ~b[6:0]);
            bus(1'b0, IDX_RX_DATA, pad);
            bus(1'b0, IDX_RX_PIN_IN, pad);
            bus(1'b0, IDX_TX_DATA, {1'b0, pt});
            bus(1'b0, IDX_TX_PIN_IN, {1'b0, pt});
            check(rxp_oe, b);
            check(rxp_out, a);
            check(rxp_rdrv, e & b);
            check(rxp_pull_en, f & ~b);
            check(rxp_pull_dn, d);
            check(txp_oe, b[6:0]);
            check(txp_out, a[6:0]);
        end
        // external mii mode takes both ports over
        rnd = lfsr(rnd);
        bus(1'b1, IDX_RX_DIR, 8'hff);
        bus(1'b1, IDX_TX_DIR, 8'h7f);
        @(posedge clock);
        mii_ext_en <= 1'b1;
        ext_rx <= rnd[7:0];
        mii_tx_out <= rnd[14:8];
        mii_tx_oe <= rnd[21:15];
        ext_tx <= rnd[28:22];
        settle(4);
        check(rxp_oe, 8'h80);
        check(rxp_pull_en, f & 8'h7f);
        check(mii_rx, rnd[6:0]);
        check(txp_out, rnd[14:8]);
        check(txp_oe, rnd[21:15]);
        check(mii_tx_in, (rnd[14:8] & rnd[21:15]) | (rnd[28:22] & ~rnd[21:15]));
        @(posedge clock);
        mii_ext_en <= 1'b0;
        settle(3);
        check(rxp_oe, 8'hff);
        check(txp_oe, 7'h7f);
        // edge flags: pin 0 falling edge, pin 1 rising edge, only pin 0 enabled
        bus(1'b1, IDX_RX_DIR, 8'h00);
        @(posedge clock);
        ext_rx <= 8'h01;
        bus(1'b1, IDX_RX_POL_SEL, 8'h02);
        bus(1'b1, IDX_RX_IRQ_EN, 8'h01);
        settle(4);
        bus(1'b1, IDX_RX_IRQ_FLG, 8'hff);
        bus(1'b0, IDX_RX_IRQ_FLG, 8'h00);
        check(port_irq, 1'b0);
        @(posedge clock);
        ext_rx <= 8'h02;
        settle(6);
        bus(1'b0, IDX_RX_IRQ_FLG, 8'h03);
        check(port_irq, 1'b1);
        bus(1'b1, IDX_RX_IRQ_FLG, 8'h00);
        bus(1'b0, IDX_RX_IRQ_FLG, 8'h03);
        bus(1'b1, IDX_RX_IRQ_FLG, 8'h01);
        bus(1'b0, IDX_RX_IRQ_FLG, 8'h02);
        // board lets go of the receive pins, pulls set the levels
        bus(1'b1, IDX_RX_PULL_EN, 8'hff);
        bus(1'b1, IDX_RX_POL_SEL, 8'h0f);
        @(posedge clock);
        ext_on <= 8'h00;
        bus(1'b0, IDX_RX_PIN_IN, 8'hf0);
        settle(2);
        check(port_irq, 1'b0);
        tally_and_finish();
    end
endmodule : port_pin_control_s_g_h_test
